// *** design/bcdadj_pkg.sv ***
package bcdadj_pkg;
    localparam logic [7:0] OPC_ADD_ADJ = 8'h37;
    localparam logic [7:0] OPC_SUB_ADJ = 8'h3F;
    localparam logic [7:0] OPC_MUL_ADJ = 8'hD4;
    localparam logic [7:0] OPC_DIV_ADJ = 8'hD5;
    localparam logic [7:0] IMM_DEFAULT = 8'h0A;
    localparam logic [3:0] NIBBLE_LIMIT = 4'h9;
    localparam logic [7:0] DECIMAL_FIX = 8'h06;
    localparam logic [7:0] LOW_NIBBLE_MASK = 8'h0F;
    localparam logic [7:0] BYTE_MASK = 8'hFF;
    localparam logic [7:0] HIGH_CLEAR = 8'h00;
    localparam int DIV_WIDTH = 8;
    localparam int DIV_CYCLES = DIV_WIDTH;
    localparam logic [4:0] FLAG_RESET = 5'h00;

    typedef enum logic [4:0] {
        BCDADJ_OP_NONE = 5'b00001,
        BCDADJ_OP_ADD = 5'b00010,
        BCDADJ_OP_SUB = 5'b00100,
        BCDADJ_OP_MUL = 5'b01000,
        BCDADJ_OP_DIV = 5'b10000
    } bcdadj_op_t;

    typedef enum logic [2:0] {
        BCDADJ_IDLE = 3'b001,
        BCDADJ_DIVIDE = 3'b010,
        BCDADJ_DONE = 3'b100
    } bcdadj_state_t;
endpackage : bcdadj_pkg

// *** design/bcdadj_divider.sv ***
module bcdadj_divider #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [WIDTH-1:0] dividend,
    input wire logic [WIDTH-1:0] divisor,
    output logic busy,
    output logic [WIDTH-1:0] quotient,
    output logic [WIDTH-1:0] remainder
);
    import bcdadj_pkg::*;

    logic [WIDTH-1:0] div_reg;
    logic [$clog2(WIDTH+1)-1:0] count;
    logic [WIDTH:0] trial;

    // Restoring division, one quotient bit a cycle
    always_comb begin
        trial = {remainder, quotient[WIDTH-1]} - {1'b0, div_reg};
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            busy <= 1'b0;
            count <= '0;
            quotient <= '0;
            remainder <= '0;
            div_reg <= '0;
        end else if (start) begin
            busy <= 1'b1;
            count <= ($clog2(WIDTH+1))'(WIDTH);
            quotient <= dividend;
            remainder <= '0;
            div_reg <= divisor;
        end else if (busy) begin
            if (trial[WIDTH]) begin
                remainder <= {remainder[WIDTH-2:0], quotient[WIDTH-1]};
                quotient <= {quotient[WIDTH-2:0], 1'b0};
            end else begin
                remainder <= trial[WIDTH-1:0];
                quotient <= {quotient[WIDTH-2:0], 1'b1};
            end
            count <= count - 1'b1;
            if (count == 1) begin
                busy <= 1'b0;
            end
        end
    end
endmodule : bcdadj_divider

// *** design/bcdadj_unit.sv ***
// Overview of operation
// RQ1 - Add adjust: low nibble over 9 or aux carry adds 6, high+1, sets both carries.
// RQ2 - Add adjust without decimal carry clears both carries, high byte unchanged.
// RQ3 - Add adjust always clears bits 4 to 7 of the low byte.
// RQ4 - After add/subtract adjust, overflow, sign, zero, parity may take any value.
// RQ5 - Opcode 37 selects add adjust on the low byte.
// RQ6 - Opcode D5 selects divide adjust on the whole word.
// RQ7 - Divide adjust: low = (low + high*imm) masked FFH, high = 00H.
// RQ8 - Multiplier or divisor is the second instruction byte, any value honoured.
// RQ9 - Divide adjust sets sign, zero, parity from result byte.
// RQ10 - Opcode D4 selects multiply adjust on the word.
// RQ11 - Multiply adjust: high = low / imm, low = low mod imm.
// RQ12 - Multiply adjust sets sign, zero, parity from result.
// RQ13 - Opcode 3F selects subtract adjust on the low byte.
// RQ14 - Subtract adjust: nibble over 9 or aux carry subtracts 6, high-1, sets carries.
// RQ15 - Subtract adjust without borrow clears both carries, high byte unchanged.
// RQ16 - Subtract adjust always clears the low byte's upper nibble.
// RQ17 - Multiply adjust with zero immediate raises divide error, no quotient.
module bcdadj_unit #(
    parameter int WIDTH = bcdadj_pkg::DIV_WIDTH
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic issue_valid,
    output logic issue_ready,
    input wire logic [7:0] opcode_byte,
    input wire logic [7:0] immediate_byte_operand,
    input wire logic [7:0] accumulator_low_byte,
    input wire logic [7:0] accumulator_high_byte,
    input wire logic auxiliary_carry_flag,
    output logic result_valid,
    output logic [7:0] result_low_byte,
    output logic [7:0] result_high_byte,
    output logic carry_flag,
    output logic auxiliary_carry_out,
    output logic overflow_flag,
    output logic sign_flag,
    output logic zero_flag,
    output logic parity_flag,
    output logic divide_error,
    output logic unknown_opcode
);
    import bcdadj_pkg::*;

    bcdadj_state_t state;
    bcdadj_op_t next_op;
    logic [7:0] next_low;
    logic [7:0] next_high;
    logic next_carry;
    logic [15:0] product;
    logic dec_adjust;
    logic div_start;
    logic div_busy;
    logic [WIDTH-1:0] div_quot;
    logic [WIDTH-1:0] div_rem;

    // Candidate results, one set each for add, subtract and divide adjust
    logic [7:0] add_low;
    logic [7:0] add_high;
    logic [7:0] sub_low;
    logic [7:0] sub_high;
    logic [7:0] div_low;
    // Handshake terms
    logic take;
    logic mul_finish;

    // Even parity over the low byte of a result
    function automatic logic parity_of(input logic [7:0] value);
        parity_of = ~^value;
    endfunction : parity_of

    // Nibble test shared by add and subtract adjust
    function automatic logic needs_adjust(input logic [7:0] value, input logic aux);
        needs_adjust = (value[3:0] > NIBBLE_LIMIT) || aux;
    endfunction : needs_adjust

    // Instructions that complete in the cycle after they are taken
    function automatic logic writes_now(input bcdadj_op_t op);
        case (op)
            BCDADJ_OP_ADD, BCDADJ_OP_SUB, BCDADJ_OP_DIV: writes_now = 1'b1;
            default: writes_now = 1'b0;
        endcase
    endfunction : writes_now

    // Sign, zero and parity of a result byte
    function automatic logic [2:0] flags_of(input logic [7:0] value);
        flags_of = {value[7], value == 8'h00, parity_of(value)};
    endfunction : flags_of

    always_comb begin
        case (opcode_byte)
            OPC_ADD_ADJ: next_op = BCDADJ_OP_ADD; // [RQ5]
            OPC_SUB_ADJ: next_op = BCDADJ_OP_SUB; // [RQ13]
            OPC_MUL_ADJ: next_op = BCDADJ_OP_MUL; // [RQ10]
            OPC_DIV_ADJ: next_op = BCDADJ_OP_DIV; // [RQ6]
            default: next_op = BCDADJ_OP_NONE;
        endcase
    end

    // Shared terms: the nibble test and the divide-adjust product
    always_comb begin
        dec_adjust = needs_adjust(accumulator_low_byte, auxiliary_carry_flag);
        product = accumulator_high_byte * immediate_byte_operand; // [RQ8]
    end

    // Add adjust path
    always_comb begin
        add_low = accumulator_low_byte;
        add_high = accumulator_high_byte;
        if (dec_adjust) begin
            add_low = accumulator_low_byte + DECIMAL_FIX; // [RQ1]
            add_high = accumulator_high_byte + 8'h01; // [RQ1]
        end
        // Otherwise high byte kept and carries cleared [RQ2]
        add_low = add_low & LOW_NIBBLE_MASK; // [RQ3]
    end

    // Subtract adjust path; a borrow out of the high byte wraps as the register would
    always_comb begin
        sub_low = accumulator_low_byte;
        sub_high = accumulator_high_byte;
        if (dec_adjust) begin
            sub_low = accumulator_low_byte - DECIMAL_FIX; // [RQ14]
            sub_high = accumulator_high_byte - 8'h01; // [RQ14]
        end
        // Otherwise high byte kept and carries cleared [RQ15]
        sub_low = sub_low & LOW_NIBBLE_MASK; // [RQ16]
    end

    // Divide adjust path: only the low byte of the product can reach the result
    always_comb begin
        div_low = (accumulator_low_byte + product[7:0]) & BYTE_MASK; // [RQ7]
    end

    // Select the path of the decoded instruction; for add and subtract both carries follow the nibble test
    always_comb begin
        next_low = accumulator_low_byte;
        next_high = accumulator_high_byte;
        next_carry = 1'b0;
        case (next_op)
            BCDADJ_OP_ADD: begin
                next_low = add_low;
                next_high = add_high;
                next_carry = dec_adjust; // [RQ1] [RQ2]
            end
            BCDADJ_OP_SUB: begin
                next_low = sub_low;
                next_high = sub_high;
                next_carry = dec_adjust; // [RQ14] [RQ15]
            end
            BCDADJ_OP_DIV: begin
                next_low = div_low;
                next_high = HIGH_CLEAR; // [RQ7]
            end
            default: begin
                next_low = accumulator_low_byte;
                next_high = accumulator_high_byte;
            end
        endcase
    end

    // Multiply adjust with nonzero divisor goes through the serial divider
    assign issue_ready = (state == BCDADJ_IDLE);
    assign take = issue_valid && issue_ready;
    assign div_start = take && (next_op == BCDADJ_OP_MUL)
        && (immediate_byte_operand != 8'h00); // [RQ17]
    // The divider drops busy one cycle before the result registers load
    assign mul_finish = (state == BCDADJ_DIVIDE) && !div_busy;

    bcdadj_divider #(
        .WIDTH(WIDTH)
    ) u_divider (
        .mclk(mclk),
        .rst_b(rst_b),
        .start(div_start),
        .dividend(accumulator_low_byte),
        .divisor(immediate_byte_operand), // [RQ8]
        .busy(div_busy),
        .quotient(div_quot),
        .remainder(div_rem)
    );

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state <= BCDADJ_IDLE;
        end else begin
            case (state)
                BCDADJ_IDLE: begin
                    if (div_start) begin
                        state <= BCDADJ_DIVIDE;
                    end
                end
                BCDADJ_DIVIDE: begin
                    if (!div_busy) begin
                        state <= BCDADJ_DONE;
                    end
                end
                BCDADJ_DONE: state <= BCDADJ_IDLE;
                default: state <= BCDADJ_IDLE;
            endcase
        end
    end

    // Result strobe: one cycle for each instruction that writes the accumulator
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            result_valid <= 1'b0;
        end else if (mul_finish) begin
            result_valid <= 1'b1;
        end else if (take) begin
            result_valid <= writes_now(next_op);
        end else begin
            result_valid <= 1'b0;
        end
    end

    // Result bytes hold until the next result replaces them
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            result_low_byte <= 8'h00;
            result_high_byte <= 8'h00;
        end else if (mul_finish) begin
            result_high_byte <= div_quot[7:0]; // [RQ11]
            result_low_byte <= div_rem[7:0]; // [RQ11]
        end else if (take && writes_now(next_op)) begin
            result_low_byte <= next_low; // [RQ3] [RQ7] [RQ16]
            result_high_byte <= next_high; // [RQ1] [RQ2] [RQ7] [RQ14] [RQ15]
        end
    end

    // Carry pair means something only after add and subtract adjust; cleared by divide and multiply adjust results, held otherwise
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            {carry_flag, auxiliary_carry_out} <= FLAG_RESET[4:3];
        end else if (mul_finish) begin
            carry_flag <= 1'b0;
            auxiliary_carry_out <= 1'b0;
        end else if (take) begin
            case (next_op)
                BCDADJ_OP_ADD, BCDADJ_OP_SUB: begin
                    carry_flag <= next_carry; // [RQ1] [RQ2] [RQ14] [RQ15]
                    auxiliary_carry_out <= next_carry; // [RQ1] [RQ2] [RQ14] [RQ15]
                end
                BCDADJ_OP_DIV: begin
                    carry_flag <= 1'b0;
                    auxiliary_carry_out <= 1'b0;
                end
                default: begin
                    carry_flag <= carry_flag;
                    auxiliary_carry_out <= auxiliary_carry_out;
                end
            endcase
        end
    end

    // Overflow is undefined after every adjust and is driven low [RQ4]
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            overflow_flag <= 1'b0;
        end else if (mul_finish || (take && writes_now(next_op))) begin
            overflow_flag <= 1'b0;
        end
    end

    // Sign, zero and parity follow the new low byte; for add and subtract this is a free choice
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            {sign_flag, zero_flag, parity_flag} <= FLAG_RESET[2:0];
        end else if (mul_finish) begin
            {sign_flag, zero_flag, parity_flag} <= flags_of(div_rem[7:0]); // [RQ12]
        end else if (take) begin
            case (next_op)
                BCDADJ_OP_ADD, BCDADJ_OP_SUB: begin
                    {sign_flag, zero_flag, parity_flag} <= flags_of(next_low); // [RQ4]
                end
                BCDADJ_OP_DIV: begin
                    {sign_flag, zero_flag, parity_flag} <= flags_of(next_low); // [RQ9]
                end
                default: begin
                    {sign_flag, zero_flag, parity_flag} <= {sign_flag, zero_flag, parity_flag};
                end
            endcase
        end
    end

    // Zero divisor: no quotient is formed, the error pulses instead
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            divide_error <= 1'b0;
        end else begin
            divide_error <= take && (next_op == BCDADJ_OP_MUL)
                && (immediate_byte_operand == 8'h00); // [RQ17]
        end
    end

    // Opcodes outside the four adjusts are flagged and leave every result untouched
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            unknown_opcode <= 1'b0;
        end else begin
            unknown_opcode <= take && (next_op == BCDADJ_OP_NONE);
        end
    end
endmodule : bcdadj_unit

// *** dv/bcdadj_chk.sv ***
module bcdadj_chk #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic issue_valid,
    input wire logic issue_ready,
    input wire logic [7:0] opcode_byte,
    input wire logic [7:0] immediate_byte_operand,
    input wire logic [7:0] accumulator_low_byte,
    input wire logic [7:0] accumulator_high_byte,
    input wire logic auxiliary_carry_flag,
    input wire logic result_valid,
    input wire logic [7:0] result_low_byte,
    input wire logic [7:0] result_high_byte,
    input wire logic carry_flag,
    input wire logic auxiliary_carry_out,
    input wire logic sign_flag,
    input wire logic zero_flag,
    input wire logic parity_flag,
    input wire logic divide_error
);
    timeunit 1ns;
    timeprecision 1ps;
    import bcdadj_pkg::*;
    wire logic [7:0] al = accumulator_low_byte;
    wire logic [7:0] ah = accumulator_high_byte;
    wire logic [7:0] im = immediate_byte_operand;
    wire logic [7:0] rl = result_low_byte;
    wire logic [7:0] rh = result_high_byte;
    wire logic take = issue_valid && issue_ready;
    wire logic fix = al[3:0] > NIBBLE_LIMIT || auxiliary_carry_flag;
    wire logic szp = sign_flag == rl[7] && zero_flag == (rl == 8'h00) && parity_flag == ~^rl;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_add; take && opcode_byte == OPC_ADD_ADJ; endsequence
    sequence s_sub; take && opcode_byte == OPC_SUB_ADJ; endsequence
    sequence s_mul; take && opcode_byte == OPC_MUL_ADJ && im != 8'h00; endsequence
    sequence s_mul_wait; (!issue_ready && !result_valid)[*8] ##1 !issue_ready; endsequence
    property p_add_fix;
        s_add ##0 fix |=> result_valid && carry_flag && auxiliary_carry_out
            && rh == $past(ah) + 8'h01 && rl == (($past(al) + 8'h06) & 8'h0F);
    endproperty
    property p_add_plain;
        s_add ##0 !fix |=> result_valid && !carry_flag && !auxiliary_carry_out && rh == $past(ah);
    endproperty
    property p_add_mask; s_add |=> rl[7:4] == 4'h0; endproperty
    property p_sub_fix;
        s_sub ##0 fix |=> result_valid && carry_flag && auxiliary_carry_out
            && rh == $past(ah) - 8'h01 && rl == (($past(al) - 8'h06) & 8'h0F);
    endproperty
    property p_sub_plain;
        s_sub ##0 !fix |=> result_valid && !carry_flag && !auxiliary_carry_out && rh == $past(ah);
    endproperty
    property p_sub_mask; s_sub |=> rl[7:4] == 4'h0; endproperty
    property p_div;
        take && opcode_byte == OPC_DIV_ADJ |=> result_valid && rh == 8'h00 && szp
            && rl == $past(al) + $past(ah) * $past(im);
    endproperty
    property p_mul;
        s_mul |=> s_mul_wait ##1 (result_valid && szp
            && rh == $past(al, 10) / $past(im, 10) && rl == $past(al, 10) % $past(im, 10));
    endproperty
    property p_mul_zero;
        take && opcode_byte == OPC_MUL_ADJ && im == 8'h00 |=> divide_error && !result_valid;
    endproperty
    a_add_fix: assert property (p_add_fix) else $error("add adjust fix wrong");
    a_add_plain: assert property (p_add_plain) else $error("add adjust plain wrong");
    a_add_mask: assert property (p_add_mask) else $error("add adjust upper nibble set");
    a_sub_fix: assert property (p_sub_fix) else $error("sub adjust fix wrong");
    a_sub_plain: assert property (p_sub_plain) else $error("sub adjust plain wrong");
    a_sub_mask: assert property (p_sub_mask) else $error("sub adjust upper nibble set");
    a_div: assert property (p_div) else $error("divide adjust wrong");
    a_mul: assert property (p_mul) else $error("multiply adjust wrong");
    a_mul_zero: assert property (p_mul_zero) else $error("zero divisor not refused");
endmodule : bcdadj_chk

bind bcdadj_unit bcdadj_chk #(.WIDTH(WIDTH)) u_chk (.*);

// *** dv/bcdadj_issuer.sv ***
module bcdadj_issuer (
    input wire logic mclk,
    input wire logic issue_ready,
    output logic issue_valid,
    output logic [7:0] opcode_byte,
    output logic [7:0] immediate_byte_operand,
    output logic [7:0] accumulator_low_byte,
    output logic [7:0] accumulator_high_byte,
    output logic auxiliary_carry_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        issue_valid = 1'b0;
        {opcode_byte, immediate_byte_operand, accumulator_low_byte} = 24'h000000;
        {accumulator_high_byte, auxiliary_carry_flag} = 9'h000;
    end
    task automatic send(input logic [7:0] o, i, l, h, input logic f);
        int n;
        n = 0;
        @(posedge mclk);
        issue_valid <= 1'b1;
        {opcode_byte, immediate_byte_operand, accumulator_low_byte} <= {o, i, l};
        {accumulator_high_byte, auxiliary_carry_flag} <= {h, f};
        do begin
            @(posedge mclk);
            n++;
        end while (issue_ready !== 1'b1 && n < 40);
        issue_valid <= 1'b0;
        // Released operands flip so a stale value can never look valid
        {opcode_byte, immediate_byte_operand, accumulator_low_byte} <= ~{o, i, l};
        {accumulator_high_byte, auxiliary_carry_flag} <= ~{h, f};
    endtask : send
endmodule : bcdadj_issuer

// *** dv/tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bcdadj_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic issue_valid, issue_ready, auxiliary_carry_flag, result_valid, carry_flag;
    logic auxiliary_carry_out, overflow_flag, sign_flag, zero_flag, parity_flag;
    logic divide_error, unknown_opcode;
    logic [7:0] opcode_byte, immediate_byte_operand, accumulator_low_byte;
    logic [7:0] accumulator_high_byte, result_low_byte, result_high_byte;
    logic [7:0] ops [4] = '{OPC_ADD_ADJ, OPC_SUB_ADJ, OPC_MUL_ADJ, OPC_DIV_ADJ};
    int err_count = 0;
    int tests_run = 0;
    always #20 mclk = ~mclk;
    bcdadj_issuer u_src (.*);
    bcdadj_unit u_dut (.*);
    function automatic logic [16:0] model(input logic [7:0] o, i, l, h, input logic f);
        logic [7:0] nl;
        logic [7:0] nh;
        logic c;
        nl = l;
        nh = h;
        c = (l[3:0] > 4'h9) || f;
        if (o == OPC_DIV_ADJ) begin
            nl = l + h * i;
            nh = 8'h00;
        end else if (o == OPC_MUL_ADJ) begin
            nh = l / i;
            nl = l % i;
        end else begin
            if (c) begin
                nl = (o == OPC_ADD_ADJ) ? l + 8'h06 : l - 8'h06;
                nh = (o == OPC_ADD_ADJ) ? h + 8'h01 : h - 8'h01;
            end
            nl = nl & 8'h0F;
        end
        return {c, nh, nl};
    endfunction : model
    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic run(input logic [7:0] o, i, l, h, input logic f);
        logic [16:0] e;
        int n;
        e = model(o, i, l, h, f);
        n = 0;
        u_src.send(o, i, l, h, f);
        do begin
            @(negedge mclk);
            n++;
        end while (result_valid !== 1'b1 && divide_error !== 1'b1 && unknown_opcode !== 1'b1
            && n < 20);
        if (o == OPC_MUL_ADJ && i == 8'h00) begin
            check("divide error", {divide_error, result_valid}, 2'b10);
        end else if (!(o inside {OPC_ADD_ADJ, OPC_SUB_ADJ, OPC_MUL_ADJ, OPC_DIV_ADJ})) begin
            check("unknown opcode", {unknown_opcode, result_valid}, 2'b10);
        end else begin
            check("valid", result_valid, 1'b1);
            check("high byte", result_high_byte, e[15:8]);
            check("low byte", result_low_byte, e[7:0]);
            check("overflow", overflow_flag, 1'b0);
            if (o == OPC_ADD_ADJ || o == OPC_SUB_ADJ) begin
                check("carry", carry_flag, e[16]);
                check("aux carry", auxiliary_carry_out, e[16]);
            end else begin
                check("carries clear", {carry_flag, auxiliary_carry_out}, 2'b00);
                check("sign", sign_flag, e[7]);
                check("zero", zero_flag, e[7:0] == 8'h00);
                check("parity", parity_flag, ~^e[7:0]);
            end
        end
    endtask : run
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    initial begin
        #(4000 * 40);
        err_count++;
        results();
    end
    initial begin
        void'($urandom(10238));
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        run(OPC_ADD_ADJ, 8'h00, 8'h09, 8'h01, 1'b0);
        run(OPC_ADD_ADJ, 8'h00, 8'h0A, 8'hFF, 1'b0);
        run(OPC_ADD_ADJ, 8'h00, 8'hF3, 8'h05, 1'b1);
        run(OPC_SUB_ADJ, 8'h00, 8'h00, 8'h00, 1'b1);
        run(OPC_SUB_ADJ, 8'h00, 8'hE9, 8'h07, 1'b0);
        run(OPC_DIV_ADJ, IMM_DEFAULT, 8'h07, 8'h03, 1'b0);
        run(OPC_DIV_ADJ, 8'hFF, 8'hFF, 8'hFF, 1'b1);
        run(OPC_MUL_ADJ, IMM_DEFAULT, 8'h25, 8'h00, 1'b0);
        run(OPC_MUL_ADJ, 8'h00, 8'h25, 8'h11, 1'b0);
        run(OPC_MUL_ADJ, 8'h01, 8'hFF, 8'h11, 1'b1);
        run(8'h27, IMM_DEFAULT, 8'h12, 8'h34, 1'b0);
        $display("test corners done");
        repeat (90) begin
            run(ops[$urandom % 4], ($urandom % 4 == 0) ? 8'h00 : 8'($urandom), 8'($urandom),
                8'($urandom), 1'($urandom));
        end
        $display("test random done");
        results();
    end
endmodule : tb
